// ===== bbs_status_reg.v
/*
  bridge bus status register: captures the device number from
  configuration writes, holds two write-one-to-clear split flags,
  builds the completer identifier.
  assumes decoded config fields, the primary bus number register and
  split engine events arrive synchronous to clk.
*/
`timescale 1ns/1ps
`include "bbs_consts.vh"
module bbs_status_reg (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        cfg_addr_valid,
  input  wire [3:0]  cfg_cmd,
  input  wire        cfg_idsel,
  input  wire [31:0] cfg_addr,
  input  wire        cfg_wr_valid,
  input  wire [3:0]  cfg_wr_be,
  input  wire [31:0] cfg_wr_data,
  input  wire [7:0]  cfg_rd_offset,
  output reg  [31:0] cfg_rd_data,
  input  wire        prim_bus_wr,
  input  wire [7:0]  prim_bus_num_in,
  input  wire        split_cpl_valid,
  input  wire [15:0] split_cpl_req_id,
  input  wire        split_req_valid,
  input  wire [15:0] split_req_size,
  input  wire [15:0] split_outstanding,
  input  wire        limit_wr,
  input  wire [15:0] limit_wr_data,
  output wire        split_req_hold,
  output wire [15:0] completer_id,
  output wire        cfg_hit
);
  wire [4:0]  dev_num;
  wire [7:0]  bus_num;
  wire [15:0] limit_num;
  wire [2:0]  func_num;
  wire [4:0]  addr_dev;
  wire [16:0] need;
  wire [16:0] room;
  wire        type0;
  wire        func_match;
  wire        cfg_wr_cmd;
  wire        own_req_id;
  wire        set_usc;
  wire        set_srd;
  wire        wr_this;
  wire        flag_lane;
  wire        clr_usc;
  wire        clr_srd;
  wire        usc_flag;
  wire        srd_flag;
  wire [31:0] status_word;
  reg  [31:0] nxt_rd_data;

  // strapped, so no write path reaches it
  assign func_num = `BBS_FUNC_RST;

  // address phase decode
  assign type0      = (cfg_addr[`BBS_TYPE_MSB:`BBS_TYPE_LSB] == `BBS_TYPE0);
  assign func_match = (cfg_addr[`BBS_FUNC_MSB:`BBS_FUNC_LSB] == func_num);
  assign cfg_wr_cmd = (cfg_cmd == `BBS_CMD_CFG_WR);
  assign cfg_hit    = cfg_addr_valid && cfg_wr_cmd && cfg_idsel &&
                      type0 && func_match;
  assign addr_dev   = cfg_addr[`BBS_DEV_MSB:`BBS_DEV_LSB];

  // identity used for split completions and conventional mode
  assign completer_id = {bus_num, dev_num, func_num};

  // one spare bit so outstanding plus size cannot wrap past the limit
  assign need = {1'b0, split_outstanding} + {1'b0, split_req_size};
  assign room = {1'b0, limit_num};

  // even a limit of ffff holds a request whose outstanding plus size exceeds it
  assign split_req_hold = split_req_valid && (need > room);
  assign set_srd        = split_req_hold;

  // a completion carrying our own id was never asked for by us
  assign own_req_id = (split_cpl_req_id == completer_id);
  assign set_usc    = split_cpl_valid && own_req_id;

  // only a one in the flag lane clears; zeros and other bits do nothing
  assign wr_this   = cfg_wr_valid && (cfg_rd_offset == `BBS_OFFSET);
  assign flag_lane = cfg_wr_be[`BBS_FLAG_LANE];
  assign clr_usc   = wr_this && flag_lane && cfg_wr_data[`BBS_BIT_USC];
  assign clr_srd   = wr_this && flag_lane && cfg_wr_data[`BBS_BIT_SRD];

  // device number, reloaded on every type 0 configuration write with idsel set that selects function 0
  bbs_load_reg #(
    .WIDTH   (5),
    .RST_VAL (`BBS_DEV_RST)
  ) u_dev_reg (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (cfg_hit),
    .d     (addr_dev),
    .q     (dev_num)
  );

  // mirror of the primary bus number register
  bbs_load_reg #(
    .WIDTH   (8),
    .RST_VAL (`BBS_BUS_RST)
  ) u_bus_reg (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (prim_bus_wr),
    .d     (prim_bus_num_in),
    .q     (bus_num)
  );

  // commitment limit in ADQ units
  bbs_load_reg #(
    .WIDTH   (16),
    .RST_VAL (`BBS_LIMIT_RST)
  ) u_limit_reg (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (limit_wr),
    .d     (limit_wr_data),
    .q     (limit_num)
  );

  bbs_w1c_flag #(
    .RST_VAL (`BBS_FLAG_RST)
  ) u_usc_flag (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (set_usc),
    .clr   (clr_usc),
    .flag  (usc_flag)
  );

  bbs_w1c_flag #(
    .RST_VAL (`BBS_FLAG_RST)
  ) u_srd_flag (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (set_srd),
    .clr   (clr_srd),
    .flag  (srd_flag)
  );

  // fixed zero bits: reserved, overrun, discarded, 133 MHz, 64-bit
  assign status_word = {`BBS_RSVD_ZERO,
                        srd_flag,
                        `BBS_FIXED_ZERO,
                        usc_flag,
                        `BBS_FIXED_ZERO,
                        `BBS_FIXED_ZERO,
                        `BBS_FIXED_ZERO,
                        bus_num,
                        dev_num,
                        func_num};

  // other offsets read zero so an outer mux can simply or the banks
  always @* begin
    nxt_rd_data = `BBS_ZERO_WORD;
    if (cfg_rd_offset == `BBS_OFFSET) begin
      nxt_rd_data = status_word;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rd_data <= `BBS_ZERO_WORD;
    end else begin
      cfg_rd_data <= nxt_rd_data;
    end
  end
endmodule

// plain load register; holds its value until the next load
module bbs_load_reg #(
  parameter               WIDTH   = 8,
  parameter [WIDTH-1:0]   RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             load,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg  [WIDTH-1:0] val_ff;
  reg  [WIDTH-1:0] nxt_val;

  always @* begin
    nxt_val = val_ff;
    if (load) begin
      nxt_val = d;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_ff <= RST_VAL;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign q = val_ff;
endmodule

// sticky event flag; a hardware event beats a software clear in the same
// cycle, so an event landing during the clear write is never lost
module bbs_w1c_flag #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input  wire     clk,
  input  wire     rst_n,
  input  wire     set,
  input  wire     clr,
  output wire     flag
);
  reg  flag_ff;
  reg  nxt_flag;

  always @* begin
    nxt_flag = flag_ff;
    if (set) begin
      nxt_flag = 1'b1;
    end else if (clr) begin
      nxt_flag = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= RST_VAL;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;
endmodule

// ===== bbs_consts.vh
/*
  constants for the bridge bus status register block.
  assumes inclusion by bare name from the design file.
*/
`ifndef BBS_CONSTS_VH
`define BBS_CONSTS_VH
`define BBS_OFFSET        8'h84
`define BBS_CMD_CFG_WR    4'hB
`define BBS_FUNC_RST      3'h0
`define BBS_DEV_RST       5'h00
`define BBS_BUS_RST       8'hFF
`define BBS_LIMIT_RST     16'h0010
`define BBS_FUNC_LSB      8
`define BBS_FUNC_MSB      10
`define BBS_DEV_LSB       11
`define BBS_DEV_MSB       15
`define BBS_BIT_USC       19
`define BBS_BIT_SRD       21
`define BBS_TYPE_LSB      0
`define BBS_TYPE_MSB      1
`define BBS_TYPE0         2'b00
`define BBS_FLAG_LANE     2
`define BBS_ZERO_WORD     32'h0000_0000
`define BBS_RSVD_ZERO     10'h000
`define BBS_FIXED_ZERO    1'b0
`define BBS_FLAG_RST      1'b0
`endif

// ===== bbs_status_reg_chk.sv
/* checker for the status register; assumes bind to the design top */
`timescale 1ns/1ps
module bbs_chk(input wire clk,rst_n,cfg_hit,input wire [7:0] cfg_rd_offset,
  input wire [31:0] cfg_rd_data,cfg_addr,input wire [15:0] completer_id);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rsv; cfg_rd_data[31:22]==0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_ro; {cfg_rd_data[20],cfg_rd_data[18:16]}==0; endproperty
  a_ro: assert property (p_ro) else $error("fixed bits set");
  property p_fn; completer_id[2:0]==0; endproperty
  a_fn: assert property (p_fn) else $error("function not zero");
  property p_cid; $past(cfg_rd_offset)==8'h84&&$stable(completer_id)
    |-> cfg_rd_data[15:0]==completer_id; endproperty
  a_cid: assert property (p_cid) else $error("id mismatch");
  property p_off; $past(cfg_rd_offset)!=8'h84 |-> cfg_rd_data==0; endproperty
  a_off: assert property (p_off) else $error("other offset");
  property p_dev; cfg_hit |=> completer_id[7:3]==$past(cfg_addr[15:11]); endproperty
  a_dev: assert property (p_dev) else $error("device not loaded");
  property p_hit; cfg_hit |-> cfg_addr[1:0]==0&&cfg_addr[10:8]==0; endproperty
  a_hit: assert property (p_hit) else $error("bad decode");
  property p_keep; !cfg_hit |=> $stable(completer_id[7:3]); endproperty
  a_keep: assert property (p_keep) else $error("device moved");
endmodule
bind bbs_status_reg bbs_chk u_chk(.*);

// ===== bbs_cfg_mst.sv
/* config master address phase; assumes a free running clk */
`timescale 1ns/1ps
module bbs_cfg_mst(input wire clk,output reg cfg_addr_valid=0,
  output reg [3:0] cfg_cmd=0,output reg cfg_idsel=0,output reg [31:0] cfg_addr=0);
  task addr(input [3:0] c,input s,input [31:0] x);
    begin
      @(negedge clk) {cfg_addr_valid,cfg_cmd,cfg_idsel,cfg_addr}<={1'b1,c,s,x};
      // released bus shows inverse, never the stale address
      @(negedge clk) {cfg_addr_valid,cfg_idsel,cfg_addr}<={2'b0,~x};
    end
  endtask
endmodule

// ===== bbs_status_reg_tb_top.sv
/* bench for the status register; assumes the master model file */
`timescale 1ns/1ps
module bbs_status_reg_tb_top;
  reg clk=0,rst_n=0,cfg_wr_valid=0,prim_bus_wr=0,split_cpl_valid=0,split_req_valid=0;
  reg limit_wr=0; reg [3:0] cfg_wr_be=0; reg [31:0] cfg_wr_data=0; reg [4:0] d;
  reg [7:0] cfg_rd_offset=0,prim_bus_num_in=0; reg [15:0] split_cpl_req_id=0;
  reg [15:0] split_req_size=0,split_outstanding=0,limit_wr_data=0;
  wire cfg_addr_valid,cfg_idsel,split_req_hold,cfg_hit; wire [3:0] cfg_cmd;
  wire [31:0] cfg_addr,cfg_rd_data; wire [15:0] completer_id; integer n_errors=0,checked=0;
`define CMP(x,y) begin checked++; if((x)!==(y)) begin n_errors++; \
  $display("wrong value %0t %h %h",$time,x,y); end end
  initial forever #20 clk=~clk;
  bbs_cfg_mst m(.*);
  bbs_status_reg dut(.*);
  function [31:0] ev(input [7:0] b,input [4:0] v,input [1:0] f);
    ev={10'h0,f[1],1'b0,f[0],3'h0,b,v,3'h0};
  endfunction
  task rdc(input [31:0] e); begin @(negedge clk); @(negedge clk) `CMP(cfg_rd_data,e) end
  endtask
  task wr(input [31:0] v); begin @(negedge clk) {cfg_wr_valid,cfg_wr_be,cfg_wr_data}={5'h1f,v};
    @(negedge clk) cfg_wr_valid=0; end
  endtask
  task end_of_test; begin if(n_errors==0&&checked>0)
    $display("bench passed");
    else
    $display("bench failed");
    $finish; end
  endtask
  initial begin #100000 n_errors++; end_of_test; end
  initial begin
    d=$urandom(10); repeat(3) @(negedge clk); rst_n=1; cfg_rd_offset=8'h84;
    rdc(ev(8'hff,0,0));
    d=$urandom; m.addr(4'hB,1,{d,11'h0}); rdc(ev(8'hff,d,0));
    m.addr(4'hB,0,{~d,11'h0}); rdc(ev(8'hff,d,0));
    m.addr(4'hB,1,{~d,11'h100}); rdc(ev(8'hff,d,0));
    prim_bus_num_in=$urandom; prim_bus_wr=1; @(negedge clk) prim_bus_wr=0;
    split_cpl_req_id={prim_bus_num_in,d,3'h0}; split_cpl_valid=1;
    @(negedge clk) split_cpl_valid=0; rdc(ev(prim_bus_num_in,d,1));
    split_req_size=17; split_req_valid=1; @(negedge clk) `CMP(split_req_hold,1'b1)
    split_req_size=16; #1 `CMP(split_req_hold,1'b0)
    split_req_valid=0; rdc(ev(prim_bus_num_in,d,3));
    wr(0); rdc(ev(prim_bus_num_in,d,3));
    wr(32'h0028_0000); rdc(ev(prim_bus_num_in,d,0));
    limit_wr_data=16'hffff; limit_wr=1; @(negedge clk) limit_wr=0;
    split_outstanding=16'h0fff; split_req_size=16'h8000|$urandom%16'h7000; split_req_valid=1;
    @(negedge clk) `CMP(split_req_hold,1'b0)
    split_req_valid=0; rdc(ev(prim_bus_num_in,d,0));
    end_of_test;
  end
endmodule
